/* File: rtl/hpe_top.v */
// Plug detector and event status registers behind the control port.
// Assumes the control port logic presents single-cycle read and write
// strobes on CLK; event inputs are single-clock signals from the core,
// only PLUG_SENSE comes from a pin.
`timescale 1ns/1ps
`default_nettype none
`include "hpe_defs.vh"

module hpe_top #(
	parameter CW      = 26,           // Debounce counter width
	parameter T1_CYC  = `HPE_DBC_T1_MS * `HPE_CLK_KHZ, // 250 ms
	parameter T2_CYC  = `HPE_DBC_T2_MS * `HPE_CLK_KHZ, // 500 ms
	parameter T3_CYC  = `HPE_DBC_T3_MS * `HPE_CLK_KHZ  // 1.0 s
) (
	input  wire        CLK,
	input  wire        RSTN,
	input  wire        PLUG_SENSE,
	input  wire [19:0] REG_ADDR,
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [7:0]  REG_WDATA,
	output reg  [7:0]  REG_RDATA,
	output reg         REG_RVALID,
	output reg         IRQ,
	input  wire        OSC_POWERDOWN,
	input  wire        PLL_START,
	input  wire        MOD_OVERFLOW,
	input  wire        OSC_READY,
	input  wire        OSC_FAULT,
	input  wire        PLL_LOCK,
	input  wire        PLL_FAULT,
	input  wire        AMP_SEQ_DONE,
	input  wire        P1_OVERLOAD,
	input  wire        P1_FRAME_LATE,
	input  wire        P1_FRAME_EARLY,
	input  wire        P1_NO_FRAME,
	input  wire        P2_OVERLOAD,
	input  wire        P2_FRAME_LATE,
	input  wire        P2_FRAME_EARLY,
	input  wire        P2_NO_FRAME,
	input  wire        BS_STUCK,
	input  wire        BS_OVERLEVEL_A,
	input  wire        BS_OVERLEVEL_B,
	input  wire        BS_SILENCE_A,
	input  wire        BS_SILENCE_B,
	input  wire        BS_RATE_MISMATCH,
	input  wire        BS_HEADER_MISSED,
	input  wire        BS_MARKER_FOUND,
	input  wire        BS_DECODER_ON
);

	// Interval for a two-bit debounce code
	function [CW-1:0] dbc_cycles;
		input [1:0] code;
		begin
			case (code)
				2'h0:    dbc_cycles = {CW{1'b0}};
				2'h1:    dbc_cycles = T1_CYC[CW-1:0];
				2'h2:    dbc_cycles = T2_CYC[CW-1:0];
				default: dbc_cycles = T3_CYC[CW-1:0];
			endcase
		end
	endfunction

	// Reset release synchroniser
	reg        rst_s1_q;              // First stage
	reg        rst_n_q;               // Released reset for the block

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Plug sense pin synchroniser
	reg        sense_s1_q;            // First stage, read by second only
	reg        sense_s2_q;            // Safe copy of the pin

	always @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sense_s1_q <= 1'b0;
			sense_s2_q <= 1'b0;
		end else begin
			sense_s1_q <= PLUG_SENSE; // see R21
			sense_s2_q <= sense_s1_q;
		end
	end

	// Software registers
	reg  [7:0] plug_cfg_q;            // Detector configuration
	reg  [7:0] mask_gen_q;            // General group mask
	reg  [4:0] mask_p1_q;             // Port one mask, bits 7:3
	reg  [4:0] mask_p2_q;             // Port two mask, bits 7:3
	reg  [7:0] mask_bs_q;             // Bitstream group mask

	// Decoded configuration fields
	wire [1:0] plug_sense_control;
	wire       plug_sense_invert;
	wire [1:0] plug_sense_rise_debounce;
	wire [1:0] plug_sense_fall_debounce;
	wire       det_on;                // Detector enabled

	assign plug_sense_control       = plug_cfg_q[`HPE_CTRL_HI:`HPE_CTRL_LO];
	assign plug_sense_invert        = plug_cfg_q[`HPE_INV_BIT];
	assign plug_sense_rise_debounce = plug_cfg_q[`HPE_RISE_HI:`HPE_RISE_LO];
	assign plug_sense_fall_debounce = plug_cfg_q[`HPE_FALL_HI:`HPE_FALL_LO];
	// Only code 11 runs; 00 and reserved codes leave it off
	assign det_on = (plug_sense_control == `HPE_CTRL_ON); // see R1

	// Register writes; bit 0 of the configuration is reserved
	always @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			plug_cfg_q <= `HPE_RST_PLUG_CFG; // see R4
			mask_gen_q <= `HPE_RST_MASK;     // see R18
			mask_p1_q  <= `HPE_RST_MASK_PORT; // see R19
			mask_p2_q  <= `HPE_RST_MASK_PORT;
			mask_bs_q  <= `HPE_RST_MASK;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`HPE_ADDR_PLUG_CFG: begin
					plug_cfg_q <= {REG_WDATA[7:1], 1'b0};
				end
				`HPE_ADDR_MASK_GEN: begin
					mask_gen_q <= REG_WDATA;
				end
				`HPE_ADDR_MASK_P1: begin
					mask_p1_q <= REG_WDATA[7:3];
				end
				`HPE_ADDR_MASK_P2: begin
					mask_p2_q <= REG_WDATA[7:3];
				end
				`HPE_ADDR_MASK_BS: begin
					mask_bs_q <= REG_WDATA;
				end
				default: begin
					// Other offsets belong elsewhere
				end
			endcase
		end
	end

	// Invert the raw detect level ahead of the debouncer
	wire       sense_adj;             // Detect level after polarity
	assign sense_adj = sense_s2_q ^ plug_sense_invert; // see R2

	// Debounced detector
	wire       plug_level;            // Debounced level, high is plugged
	wire       plug_rise;             // Debounced plug-in pulse
	wire       plug_fall;             // Debounced removal pulse

	hpe_debounce #(
		.CW       (CW)
	) u_debounce (
		.clk      (CLK),
		.rst_n    (rst_n_q),
		.enable   (det_on),
		.din      (sense_adj),
		.rise_cyc (dbc_cycles(plug_sense_rise_debounce)), // see R3
		.fall_cyc (dbc_cycles(plug_sense_fall_debounce)), // see R4
		.level_q  (plug_level),
		.rise_q   (plug_rise),
		.fall_q   (plug_fall)
	);

	// Debounced state bits; both read zero while powered down
	wire       debounced_plugged_state;
	wire       debounced_unplugged_state;
	assign debounced_plugged_state   = det_on & plug_level;  // see R5
	assign debounced_unplugged_state = det_on & ~plug_level; // see R5

	// Read decode and clear-on-read strobes
	wire       rd_gen;                // Reading general status
	wire       rd_p1;                 // Reading port one status
	wire       rd_p2;                 // Reading port two status
	wire       rd_bs;                 // Reading bitstream status
	assign rd_gen = REG_RD & (REG_ADDR == `HPE_ADDR_STAT_GEN);
	assign rd_p1  = REG_RD & (REG_ADDR == `HPE_ADDR_STAT_P1);
	assign rd_p2  = REG_RD & (REG_ADDR == `HPE_ADDR_STAT_P2);
	assign rd_bs  = REG_RD & (REG_ADDR == `HPE_ADDR_STAT_BS);

	// Status group outputs
	wire [7:0] stat_gen;
	wire [7:0] stat_p1;
	wire [7:0] stat_p2;
	wire [7:0] stat_bs;
	wire       pend_gen;
	wire       pend_p1;
	wire       pend_p2;
	wire       pend_bs;

	// General group events
	wire [7:0] set_gen;
	wire [7:0] clr_gen;
	wire [7:0] det_clr;               // Plug flags forced clear when off

	assign set_gen[7] = MOD_OVERFLOW;                // see R7
	assign set_gen[6] = plug_rise;                   // see R6
	assign set_gen[5] = plug_fall;                   // see R6
	assign set_gen[4] = OSC_READY & ~OSC_POWERDOWN;  // see R8
	assign set_gen[3] = OSC_FAULT & ~OSC_POWERDOWN;  // see R8
	assign set_gen[2] = PLL_LOCK & PLL_START;        // see R9
	assign set_gen[1] = PLL_FAULT & PLL_START;       // see R9
	assign set_gen[0] = AMP_SEQ_DONE;                // see R10

	assign det_clr = det_on ? 8'h00 :
		((8'h01 << `HPE_BIT_PLUG) | (8'h01 << `HPE_BIT_UNPLUG)); // see R1
	assign clr_gen = (rd_gen ? stat_gen : 8'h00) | det_clr;

	hpe_sticky u_stat_gen (
		.clk    (CLK),
		.rst_n  (rst_n_q),
		.set    (set_gen),
		.clr    (clr_gen),
		.mask   (mask_gen_q),
		.stat_q (stat_gen),
		.pend   (pend_gen)
	);

	// Port one flags; bit 6 is late or early
	wire [7:0] set_p1;
	assign set_p1 = {P1_OVERLOAD, P1_FRAME_LATE | P1_FRAME_EARLY, // see R11
		P1_FRAME_LATE, P1_FRAME_EARLY, P1_NO_FRAME, 3'h0};

	hpe_sticky u_stat_p1 (
		.clk    (CLK),
		.rst_n  (rst_n_q),
		.set    (set_p1),
		.clr    (rd_p1 ? stat_p1 : 8'h00),
		.mask   ({mask_p1_q, `HPE_MASK_P1_RSVD}),
		.stat_q (stat_p1),
		.pend   (pend_p1)
	);

	// Port two flags at the same positions
	wire [7:0] set_p2;
	assign set_p2 = {P2_OVERLOAD, P2_FRAME_LATE | P2_FRAME_EARLY, // see R12
		P2_FRAME_LATE, P2_FRAME_EARLY, P2_NO_FRAME, 3'h0};

	hpe_sticky u_stat_p2 (
		.clk    (CLK),
		.rst_n  (rst_n_q),
		.set    (set_p2),
		.clr    (rd_p2 ? stat_p2 : 8'h00),
		.mask   ({mask_p2_q, 3'h7}),
		.stat_q (stat_p2),
		.pend   (pend_p2)
	);

	// Bitstream checker flags
	wire [7:0] set_bs;
	assign set_bs[7] = BS_STUCK;                           // see R13
	assign set_bs[6] = BS_OVERLEVEL_A;                     // see R14
	assign set_bs[5] = BS_OVERLEVEL_B;                     // see R14
	assign set_bs[4] = BS_SILENCE_A;                       // see R15
	assign set_bs[3] = BS_SILENCE_B;                       // see R15
	assign set_bs[2] = BS_RATE_MISMATCH | BS_HEADER_MISSED; // see R16
	assign set_bs[1] = BS_MARKER_FOUND;                    // see R17
	assign set_bs[0] = BS_DECODER_ON;                      // see R17

	hpe_sticky u_stat_bs (
		.clk    (CLK),
		.rst_n  (rst_n_q),
		.set    (set_bs),
		.clr    (rd_bs ? stat_bs : 8'h00),
		.mask   (mask_bs_q),
		.stat_q (stat_bs),
		.pend   (pend_bs)
	);

	// Read data mux; unmapped offsets read zero
	reg  [7:0] rdata_d;

	always @* begin
		case (REG_ADDR)
			`HPE_ADDR_PLUG_CFG:   rdata_d = plug_cfg_q;
			`HPE_ADDR_PLUG_STATE: rdata_d = {1'b0, debounced_plugged_state,
				debounced_unplugged_state, 5'h00}; // see R5
			`HPE_ADDR_STAT_GEN:   rdata_d = stat_gen;
			`HPE_ADDR_STAT_P1:    rdata_d = stat_p1;
			`HPE_ADDR_STAT_P2:    rdata_d = stat_p2;
			`HPE_ADDR_STAT_BS:    rdata_d = stat_bs;
			`HPE_ADDR_MASK_GEN:   rdata_d = mask_gen_q;
			`HPE_ADDR_MASK_P1:    rdata_d = {mask_p1_q, `HPE_MASK_P1_RSVD};
			`HPE_ADDR_MASK_P2:    rdata_d = {mask_p2_q, `HPE_MASK_P2_RSVD};
			`HPE_ADDR_MASK_BS:    rdata_d = mask_bs_q;
			default:              rdata_d = 8'h00;
		endcase
	end

	// Registered read answer and interrupt line
	always @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
			IRQ        <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD)
				REG_RDATA <= rdata_d;
			IRQ <= pend_gen | pend_p1 | pend_p2 | pend_bs; // see R20
		end
	end

endmodule // hpe_top

`default_nettype wire

/* File: rtl/hpe_defs.vh */
// Constants for the plug detector and event status block.
// Included by the top design file of the block; definitions only.
//
// Operation
// R1: Control 00 powers down detector, clears flags
// R2: Invert bit flips raw detect input
// R3: Rising edge debounce 0, 250, 500, 1000 ms
// R4: Falling edge debounce, same codes, reset 500
// R5: Read-only debounced plugged and unplugged bits
// R6: Plug sets bit 6, unplug bit 5
// R7: Modulator overflow sets general bit 7
// R8: Oscillator ready/fault flagged after powerdown cleared
// R9: PLL ready/fault flagged after start set
// R10: Amplifier power sequence done sets bit 0
// R11: Port one overload, error, late, early, noframe
// R12: Port two same five flags
// R13: Stuck bitstream channel sets bit 7
// R14: Overlevel per channel, bits 6 and 5
// R15: Silence pattern per channel, bits 4 and 3
// R16: Rate mismatch or missed header sets bit 2
// R17: Marker found bit 1, decoder on bit 0
// R18: General mask, one masks, resets all ones
// R19: Port and bitstream masks, reset masked
// R20: Interrupt when unmasked flag set; flags sticky
// R21: Synchronise detect input, full interval debounce
`ifndef HPE_DEFS_VH
`define HPE_DEFS_VH

// Register offsets
`define HPE_ADDR_PLUG_CFG    20'hD0000
`define HPE_ADDR_PLUG_STATE  20'hD0001
`define HPE_ADDR_STAT_GEN    20'hF0000
`define HPE_ADDR_STAT_P1     20'hF0001
`define HPE_ADDR_STAT_P2     20'hF0002
`define HPE_ADDR_STAT_BS     20'hF0004
`define HPE_ADDR_MASK_GEN    20'hF0010
`define HPE_ADDR_MASK_P1     20'hF0011
`define HPE_ADDR_MASK_P2     20'hF0012
`define HPE_ADDR_MASK_BS     20'hF0014

// Reset values
`define HPE_RST_PLUG_CFG     8'h04
`define HPE_RST_MASK         8'hFF
`define HPE_RST_MASK_PORT    5'h1F
`define HPE_MASK_P1_RSVD     3'h7
`define HPE_MASK_P2_RSVD     3'h0

// Configuration field positions
`define HPE_CTRL_HI          7
`define HPE_CTRL_LO          6
`define HPE_INV_BIT          5
`define HPE_RISE_HI          4
`define HPE_RISE_LO          3
`define HPE_FALL_HI          2
`define HPE_FALL_LO          1
`define HPE_CTRL_ON          2'h3

// Status field positions
`define HPE_BIT_PLUG         6
`define HPE_BIT_UNPLUG       5

// Debounce times in milliseconds and clock rate in kHz
`define HPE_DBC_T1_MS        250
`define HPE_DBC_T2_MS        500
`define HPE_DBC_T3_MS        1000
`define HPE_CLK_KHZ          40000

`endif

/* File: rtl/hpe_debounce.v */
// Edge-dependent debouncer for the synchronised plug detect level.
// Assumes a clean single-clock input and interval counts from the parent.
`timescale 1ns/1ps
`default_nettype none

module hpe_debounce #(
	parameter CW = 26                 // Counter width
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          enable,
	input  wire          din,
	input  wire [CW-1:0] rise_cyc,
	input  wire [CW-1:0] fall_cyc,
	output reg           level_q,
	output reg           rise_q,
	output reg           fall_q
);

	reg  [CW-1:0] cnt_q;              // Cycles the new level has held
	wire [CW-1:0] target;             // Interval for the pending edge

	// Pick interval by direction of the pending change
	assign target = din ? rise_cyc : fall_cyc; // see R3 see R4

	// Count a stable differing level; commit only after full interval
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= {CW{1'b0}};
			level_q <= 1'b0;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end else if (!enable) begin
			// Powered down: no state, no events
			cnt_q   <= {CW{1'b0}}; // see R1
			level_q <= 1'b0;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end else if (din == level_q) begin
			// Bounce back restarts the interval
			cnt_q  <= {CW{1'b0}};
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (cnt_q >= target) begin
			// Interval elapsed: take the new level
			cnt_q   <= {CW{1'b0}}; // see R21
			level_q <= din;
			rise_q  <= din;
			fall_q  <= ~din;
		end else begin
			cnt_q  <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
	end

endmodule // hpe_debounce

`default_nettype wire

/* File: rtl/hpe_sticky.v */
// One group of eight sticky event flags with a mask.
// Assumes set and clear vectors come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module hpe_sticky (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [7:0] set,
	input  wire [7:0] clr,
	input  wire [7:0] mask,
	output reg  [7:0] stat_q,
	output wire       pend
);

	// Latch events; a set in the clearing cycle survives
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			stat_q <= 8'h00;
		else
			stat_q <= (stat_q & ~clr) | set; // see R20
	end

	// Any flag whose mask bit is zero is pending
	assign pend = |(stat_q & ~mask); // see R18 see R19

endmodule // hpe_sticky

`default_nettype wire

/* File: test/hpe_top_monitor.sv */
// Concurrent checks on the register port of the plug detector block.
// Bound to hpe_top; sees its ports only, single clock domain.
`timescale 1ns/1ps
`default_nettype none

module hpe_top_monitor (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic [19:0] REG_ADDR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        REG_RVALID,
	input wire logic        MOD_OVERFLOW,
	input wire logic        P1_OVERLOAD,
	input wire logic        P1_FRAME_LATE,
	input wire logic        P1_FRAME_EARLY,
	input wire logic        P1_NO_FRAME
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	// Reads of particular places
	wire rd_gen   = REG_RD && REG_ADDR == 20'hF0000;  // General status read
	wire rd_p1    = REG_RD && REG_ADDR == 20'hF0001;  // Port one status read
	wire p1_quiet = !(P1_OVERLOAD || P1_FRAME_LATE || P1_FRAME_EARLY || P1_NO_FRAME);

	// Overflow event, two idle cycles, then a general status read
	sequence s_ovf_read;
		MOD_OVERFLOW ##1 !rd_gen [*2] ##1 rd_gen;
	endsequence
	// Two back-to-back port one reads with no event at the first
	sequence s_p1_twice;
		(rd_p1 && p1_quiet) ##1 rd_p1;
	endsequence

	read_answer_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read without answer");
	no_stray_a: assert property (!REG_RD |=> !REG_RVALID)
		else $error("answer without read");
	data_holds_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
		else $error("read data moved without answer");
	unmapped_zero_a: assert property (REG_RD && REG_ADDR == 20'hF0003 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	cfg_spare_a: assert property (REG_RD && REG_ADDR == 20'hD0000 |=> !REG_RDATA[0])
		else $error("config bit 0 not zero");
	state_bits_a: assert property (REG_RD && REG_ADDR == 20'hD0001 |=>
		(REG_RDATA & 8'h9F) == 8'h00 && !(REG_RDATA[6] && REG_RDATA[5]))
		else $error("state bits inconsistent");
	port_error_or_a: assert property (rd_p1 |=>
		REG_RDATA[2:0] == 3'h0 && REG_RDATA[6] == (REG_RDATA[5] | REG_RDATA[4]))
		else $error("port error flag not late or early");
	mask_spare_a: assert property (REG_RD && REG_ADDR == 20'hF0011 |=> REG_RDATA[2:0] == 3'h7)
		else $error("port one mask spare bits wrong");
	ovf_sticky_a: assert property (s_ovf_read |=> REG_RDATA[7])
		else $error("overflow flag not held");
	read_clears_a: assert property (s_p1_twice |=> REG_RDATA == 8'h00)
		else $error("port one flags not cleared by read");
endmodule // hpe_top_monitor

bind hpe_top hpe_top_monitor i_mon (
	.CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .MOD_OVERFLOW(MOD_OVERFLOW), .P1_OVERLOAD(P1_OVERLOAD),
	.P1_FRAME_LATE(P1_FRAME_LATE), .P1_FRAME_EARLY(P1_FRAME_EARLY), .P1_NO_FRAME(P1_NO_FRAME)
);

`default_nettype wire

/* File: test/test_plug_detect_config_and_event_status.sv */
// Self-checking bench for the plug detector and event status block.
// Drives every port of hpe_top directly; debounce counts are shortened.
`timescale 1ns/1ps
`default_nettype none

module test_plug_detect_config_and_event_status;
	localparam int T1 = 10;  // Short 250 ms count
	localparam int T2 = 20;  // Short 500 ms count
	localparam int T3 = 40;  // Short 1.0 s count
	// Expected status per event input
	localparam logic [0:22][7:0] EXP = {8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
		8'h80, 8'h60, 8'h50, 8'h08, 8'h80, 8'h60, 8'h50, 8'h08,
		8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01};
	// Reset table: places and values
	localparam logic [0:10][19:0] RA = {20'hD0000, 20'hD0001, 20'hF0000, 20'hF0001,
		20'hF0002, 20'hF0004, 20'hF0010, 20'hF0011, 20'hF0012, 20'hF0014, 20'hF0003};
	localparam logic [0:10][7:0] RV = {8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'hF8, 8'hFF, 8'h00};
	logic        clk, rstn, sense, wr, rd, irq, rvalid, osc_pd, pll_go;
	logic [19:0] addr, ma;
	logic [7:0]  wdata, rdata, got;
	logic [22:0] ev;      // Event inputs
	int          fail_count, num_checks, n, i, c, tn;

	hpe_top #(.T1_CYC(T1), .T2_CYC(T2), .T3_CYC(T3)) i_dut (
		.CLK(clk), .RSTN(rstn), .PLUG_SENSE(sense), .REG_ADDR(addr), .REG_WR(wr),
		.REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .IRQ(irq),
		.OSC_POWERDOWN(osc_pd), .PLL_START(pll_go), .MOD_OVERFLOW(ev[0]),
		.OSC_READY(ev[1]), .OSC_FAULT(ev[2]), .PLL_LOCK(ev[3]), .PLL_FAULT(ev[4]),
		.AMP_SEQ_DONE(ev[5]), .P1_OVERLOAD(ev[6]), .P1_FRAME_LATE(ev[7]),
		.P1_FRAME_EARLY(ev[8]), .P1_NO_FRAME(ev[9]), .P2_OVERLOAD(ev[10]),
		.P2_FRAME_LATE(ev[11]), .P2_FRAME_EARLY(ev[12]), .P2_NO_FRAME(ev[13]),
		.BS_STUCK(ev[14]), .BS_OVERLEVEL_A(ev[15]), .BS_OVERLEVEL_B(ev[16]),
		.BS_SILENCE_A(ev[17]), .BS_SILENCE_B(ev[18]), .BS_RATE_MISMATCH(ev[19]),
		.BS_HEADER_MISSED(ev[20]), .BS_MARKER_FOUND(ev[21]), .BS_DECODER_ON(ev[22])
	);

	// 40 MHz clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic final_report;
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// One write strobe
	task automatic wreg(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		wr = 1;
		addr = a;
		wdata = d;
		@(posedge clk) #1;
		wr = 0;
	endtask

	// One read strobe; answer is looked at in its one cycle
	task automatic rreg(input logic [19:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		rd = 1;
		addr = a;
		@(posedge clk) #1;
		rd = 0;
		chk({7'h00, rvalid}, 8'h01);
		d = rdata;
	endtask

	task automatic rchk(input logic [19:0] a, input logic [7:0] e);
		rreg(a, got);
		chk(got, e);
	endtask

	// One-cycle event pulse
	task automatic pulse(input int k);
		@(posedge clk) #1;
		ev[k] = 1;
		@(posedge clk) #1;
		ev[k] = 0;
	endtask

	// Poll the state register; cycles taken must fall in lo..hi
	task automatic wait_state(input logic [7:0] want, input int lo, input int hi);
		n = 0;
		got = 8'h00;
		while (got !== want) begin
			rreg(20'hD0001, got);
			n += 2;
			if (n > hi + 10) begin
				fail_count++;
				final_report;
			end
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
	endtask

	initial begin
		rstn = 0;
		sense = 0;
		wr = 0;
		rd = 0;
		addr = 0;
		wdata = 0;
		ev = 0;
		osc_pd = 0;
		pll_go = 1;
		fail_count = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		#1 rstn = 1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 11; i++) rchk(RA[i], RV[i]);
		// Read-only, unmapped and config spare bit
		wreg(20'hF0000, 8'hFF);
		rchk(20'hF0000, 8'h00);
		wreg(20'hF0003, 8'h55);
		rchk(20'hF0003, 8'h00);
		wreg(20'hD0000, 8'hFF);
		rchk(20'hD0000, 8'hFE);
		// Disabled and reserved control codes report nothing
		for (c = 0; c < 3; c++) begin
			wreg(20'hD0000, {c[1:0], 6'h20});
			repeat (4) @(posedge clk);
			rchk(20'hD0001, 8'h00);
		end
		// Debounce times per code, with a short glitch first
		for (c = 1; c < 4; c++) begin
			tn = c == 1 ? T1 : c == 2 ? T2 : T3;
			wreg(20'hD0000, 8'hC0 | 8'(c << 3) | 8'(c << 1));
			rreg(20'hF0000, got);
			sense = 1;
			repeat (tn - 4) @(posedge clk);
			#1 sense = 0;
			repeat (3) @(posedge clk);
			#1 sense = 1;
			wait_state(8'h40, tn + 1, tn + 9);
			rchk(20'hF0000, 8'h40);
			sense = 0;
			wait_state(8'h20, tn + 1, tn + 9);
			rchk(20'hF0000, 8'h20);
		end
		// Inverted input, zero debounce
		wreg(20'hD0000, 8'hE0);
		wait_state(8'h40, 1, 10);
		sense = 1;
		wait_state(8'h20, 1, 10);
		sense = 0;
		wait_state(8'h40, 1, 10);
		wreg(20'hD0000, 8'h00);
		rchk(20'hD0001, 8'h00);
		rchk(20'hF0000, 8'h00);
		// Unmask every group
		for (c = 0; c < 4; c++) begin
			ma = 20'hF0010 + 20'(c == 3 ? 4 : c);
			wreg(ma, 8'h00);
			rchk(ma, c == 1 ? 8'h07 : 8'h00);
		end
		// Every event input: its flag, interrupt and clear by read
		for (i = 0; i < 23; i++) begin
			pulse(i);
			@(posedge clk) #1;
			chk({7'h00, irq}, 8'h01);
			ma = i < 6 ? 20'hF0000 : i < 10 ? 20'hF0001 : i < 14 ? 20'hF0002 : 20'hF0004;
			rchk(ma, EXP[i]);
			@(posedge clk) #1;
			chk({7'h00, irq}, 8'h00);
			rchk(ma, 8'h00);
		end
		// Oscillator and PLL flags blocked by their controls
		osc_pd = 1;
		pll_go = 0;
		for (i = 1; i < 5; i++) pulse(i);
		rchk(20'hF0000, 8'h00);
		// Masked flag keeps the interrupt low
		wreg(20'hF0010, 8'h80);
		pulse(0);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		pulse(5);
		repeat (2) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h01);
		rchk(20'hF0000, 8'h81);
		// Back-to-back reads: second one finds the flags cleared
		pulse(7);
		@(posedge clk) #1;
		rd = 1;
		addr = 20'hF0001;
		@(posedge clk) #1;
		chk(rdata, 8'h60);
		@(posedge clk) #1;
		rd = 0;
		chk(rdata, 8'h00);
		final_report;
	end
endmodule // test_plug_detect_config_and_event_status

`default_nettype wire
